// ==== core/nvm_ctrl_pkg.sv ====
// package for the data eeprom access controller: register map, bit fields,
// unlock keys, states and the controller state record.
// assumes one 40 MHz clock and a 32-bit axi4-lite register bus.
`default_nettype none
package nvm_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] OFS_ACCESS_CONTROL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_UNLOCK_KEY = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_DATA_PORT = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFS_ADDRESS_LOW = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] OFS_ADDRESS_HIGH = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] OFS_FLAGS_2 = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] OFS_ENABLES_2 = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] OFS_PRIORITY_2 = 8'h1C;

  // ----------------------------------------------------------------------
  // access control fields
  // ----------------------------------------------------------------------
  localparam int BIT_PROGRAM_SPACE = 7;
  localparam int BIT_CONFIG_SPACE = 6;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_WRITE_ABORT = 3;
  localparam int BIT_WRITE_ENABLE = 2;
  localparam int BIT_WRITE_START = 1;
  localparam int BIT_READ_START = 0;
  localparam int BIT_WRITE_COMPLETE = 4;

  // ----------------------------------------------------------------------
  // array, keys, timing
  // ----------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int EE_ADDR_W = 10;
  localparam int EE_DEPTH = 1024;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 4000000;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_NONE, SEL_CTRL, SEL_KEY, SEL_DATA, SEL_ADRL, SEL_ADRH, SEL_FLAGS, SEL_EN, SEL_PRIO
  } reg_sel_e;
  typedef enum logic [1:0] {UNL_IDLE, UNL_FIRST, UNL_ARMED} unlock_e;
  typedef enum logic [1:0] {PH_IDLE, PH_ERASE, PH_PROGRAM} phase_e;
  typedef enum logic [1:0] {TGT_EEPROM, TGT_FLASH, TGT_CONFIG} target_e;

  // command towards the flash / configuration write machinery
  typedef struct packed {
    logic start;
    logic row_erase;
    target_e target;
    logic busy;
  } nvm_cmd_s;

  typedef struct packed {
    logic program_space;
    logic config_space;
    logic row_erase;
    logic write_abort;
    logic write_enable;
    logic write_start;
    logic read_start;
    logic read_fetch;
    logic [BYTE_W-1:0] data;
    logic [EE_ADDR_W-1:0] addr;
    logic wc_flag;
    logic wc_ie;
    logic wc_ip;
    unlock_e unlock;
    phase_e phase;
    target_e target;
    logic [CNT_W-1:0] cnt;
    logic cmd_start;
    logic aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [BYTE_W-1:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

endpackage
`default_nettype wire

// ==== core/eeprom_byte_array.sv ====
// byte array standing in for the data eeprom cells.
// assumes one clock; read data come out of a register one cycle after re.
`default_nettype none
module eeprom_byte_array #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  // no reset: contents are nonvolatile across any reset
  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
    if (re) begin
      rdata <= cells[raddr];
    end
  end

endmodule
`default_nettype wire

// ==== core/nvm_access_ctrl.sv ====
// data eeprom access controller: control, unlock key, data and address
// registers behind an axi4-lite slave, self-timed erase-then-program cycle.
// assumes a 40 MHz aclk, a bus master on the same clock, and a flash side
// that follows nvm_cmd for program-space and configuration targets.
`default_nettype none

// Behaviour
// RULE1: program-space select 0 targets data eeprom, 1 targets program flash.
// RULE2: config-space select 1 targets configuration; else program-space select decides.
// RULE3: low address gives 8 bits, high address adds two, 1024 bytes total.
// RULE4: writes only while write enable is 1; enable cleared at power-up.
// RULE5: write-abort flag set at write start, cleared when timer completes write.
// RULE6: write-abort flag stays 1 after reset mid-write or improper attempt.
// RULE7: write start only settable by software, cleared by hardware at completion.
// RULE8: write-complete flag set at completion; only software clears it.
// RULE9: read start fetches the byte, then hardware clears it; software only sets.
// RULE10: read start refused while either space select bit is 1.
// RULE11: read data held in data register until next read or software write.
// RULE12: unlock-key location has no storage and reads all zeros.
// RULE13: row-erase enable makes next write an erase; completion clears it (code clears it only when a program-flash write completes).
// RULE14: each eeprom byte write erases the location first, timed on chip.
// RULE15: write abort leaves the space select bits unchanged.
// RULE16: power-on clears enables and starts; bit 5 reads zero.
// RULE17: software reads by loading address, clearing select, setting read start.
// RULE18: write starts only after 55h then AAh to the key, then start.
// RULE19: start blocked unless enable already 1; not both in one write.
// RULE20: control, address and data writes ignored while a write runs.
// RULE21: write duration is a parameterised cycle count.
// RULE22: interrupt request raised when completion flag and enable are both 1.
module nvm_access_ctrl
  import nvm_ctrl_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
  parameter int ERASE_CYCLES = WRITE_CYCLES / 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output nvm_cmd_s nvm_cmd,
  output logic irq_req,
  output logic irq_high_priority
);

  // ----------------------------------------------------------------------
  // constants and helpers
  // ----------------------------------------------------------------------
  localparam state_s STATE_POR = '0;
  localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_CYCLES - 1);
  localparam logic [CNT_W-1:0] PROGRAM_LAST = CNT_W'(WRITE_CYCLES - ERASE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  function automatic reg_sel_e decode(input logic [AXI_ADDR_W-1:0] a);
    unique case (a)
      OFS_ACCESS_CONTROL: decode = SEL_CTRL;
      OFS_UNLOCK_KEY: decode = SEL_KEY;
      OFS_DATA_PORT: decode = SEL_DATA;
      OFS_ADDRESS_LOW: decode = SEL_ADRL;
      OFS_ADDRESS_HIGH: decode = SEL_ADRH;
      OFS_FLAGS_2: decode = SEL_FLAGS;
      OFS_ENABLES_2: decode = SEL_EN;
      OFS_PRIORITY_2: decode = SEL_PRIO;
      default: decode = SEL_NONE;
    endcase
  endfunction

  state_s s_reg;
  state_s s_next;
  state_s warm;
  logic [BYTE_W-1:0] mem_rdata;
  logic mem_we;
  logic [BYTE_W-1:0] mem_wdata;
  logic mem_re;
  logic busy;
  logic do_write;
  reg_sel_e wsel;
  reg_sel_e rsel;
  logic [BYTE_W-1:0] wd;
  logic [31:0] rval;
  target_e new_target;
  logic start_legal;

  eeprom_byte_array #(
    .WIDTH(BYTE_W),
    .DEPTH(EE_DEPTH),
    .AW(EE_ADDR_W)
  ) u_array (
    .aclk(aclk),
    .we(mem_we),
    .waddr(s_reg.addr),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(s_reg.addr),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------------
  always_comb begin
    rsel = decode(s_axi_araddr);
    rval = '0;
    unique case (rsel)
      SEL_CTRL: begin
        rval[BIT_PROGRAM_SPACE] = s_reg.program_space;
        rval[BIT_CONFIG_SPACE] = s_reg.config_space;
        rval[BIT_ROW_ERASE] = s_reg.row_erase;
        rval[BIT_WRITE_ABORT] = s_reg.write_abort;
        rval[BIT_WRITE_ENABLE] = s_reg.write_enable;
        rval[BIT_WRITE_START] = s_reg.write_start;
        rval[BIT_READ_START] = s_reg.read_start; // bit 5 stays zero [RULE16]
      end
      SEL_KEY: rval = '0; // [RULE12]
      SEL_DATA: rval[BYTE_W-1:0] = s_reg.data;
      SEL_ADRL: rval[BYTE_W-1:0] = s_reg.addr[BYTE_W-1:0];
      SEL_ADRH: rval[EE_ADDR_W-BYTE_W-1:0] = s_reg.addr[EE_ADDR_W-1:BYTE_W]; // [RULE3]
      SEL_FLAGS: rval[BIT_WRITE_COMPLETE] = s_reg.wc_flag;
      SEL_EN: rval[BIT_WRITE_COMPLETE] = s_reg.wc_ie;
      SEL_PRIO: rval[BIT_WRITE_COMPLETE] = s_reg.wc_ip;
      SEL_NONE: rval = '0;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.cmd_start = 1'b0;
    mem_we = 1'b0;
    mem_wdata = s_reg.data;
    mem_re = 1'b0;
    busy = (s_reg.phase != PH_IDLE);
    wsel = decode(s_reg.aw_addr);
    wd = s_reg.w_data;
    new_target = TGT_EEPROM;
    start_legal = 1'b0;

    // axi write address / data, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata[BYTE_W-1:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;

    // read completion from the array [RULE11]
    if (s_reg.read_start) begin
      mem_re = 1'b1;
      s_next.read_start = 1'b0; // [RULE9]
      s_next.read_fetch = 1'b1;
    end
    if (s_reg.read_fetch) begin
      s_next.read_fetch = 1'b0;
      s_next.data = mem_rdata; // [RULE9] [RULE11]
    end

    // register writes
    if (do_write) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // any byte-lane-0 write other than the next key step breaks the sequence [RULE18]
      if (s_reg.w_lane0) begin
        s_next.unlock = UNL_IDLE;
        unique case (wsel)
          SEL_KEY: begin
            if (wd == KEY_FIRST) begin
              s_next.unlock = UNL_FIRST; // [RULE18]
            end else if (wd == KEY_SECOND && s_reg.unlock == UNL_FIRST) begin
              s_next.unlock = UNL_ARMED; // [RULE18]
            end
          end
          SEL_CTRL: begin
            if (!busy) begin // [RULE20]
              s_next.program_space = wd[BIT_PROGRAM_SPACE];
              s_next.config_space = wd[BIT_CONFIG_SPACE];
              s_next.row_erase = wd[BIT_ROW_ERASE];
              s_next.write_abort = wd[BIT_WRITE_ABORT];
              s_next.write_enable = wd[BIT_WRITE_ENABLE];
              if (wd[BIT_CONFIG_SPACE]) begin
                new_target = TGT_CONFIG; // [RULE2]
              end else if (wd[BIT_PROGRAM_SPACE]) begin
                new_target = TGT_FLASH; // [RULE1]
              end
              // enable must already be set; same-write enable does not count
              start_legal = s_reg.write_enable && s_reg.unlock == UNL_ARMED; // [RULE4] [RULE19]
              if (wd[BIT_WRITE_START] && start_legal) begin
                s_next.write_start = 1'b1; // [RULE7]
                s_next.write_abort = 1'b1; // [RULE5]
                s_next.phase = PH_ERASE;
                s_next.cnt = '0;
                s_next.target = new_target;
                s_next.cmd_start = 1'b1;
                // erase the cell before programming it [RULE14]
                mem_we = (new_target == TGT_EEPROM);
                mem_wdata = ERASED_BYTE;
              end else begin
                if (wd[BIT_WRITE_START]) begin
                  s_next.write_abort = 1'b1; // improper attempt [RULE6] [RULE19]
                end
                if (wd[BIT_READ_START] && !wd[BIT_PROGRAM_SPACE]
                    && !wd[BIT_CONFIG_SPACE]) begin
                  s_next.read_start = 1'b1; // [RULE10]
                end
              end
            end
          end
          SEL_DATA: begin
            if (!busy && !s_reg.read_fetch) begin
              s_next.data = wd; // [RULE11] [RULE20]
            end
          end
          SEL_ADRL: begin
            if (!busy) begin
              s_next.addr[BYTE_W-1:0] = wd; // [RULE3] [RULE20]
            end
          end
          SEL_ADRH: begin
            if (!busy) begin
              s_next.addr[EE_ADDR_W-1:BYTE_W] = wd[EE_ADDR_W-BYTE_W-1:0]; // [RULE3]
            end
          end
          SEL_FLAGS: s_next.wc_flag = wd[BIT_WRITE_COMPLETE];
          SEL_EN: s_next.wc_ie = wd[BIT_WRITE_COMPLETE];
          SEL_PRIO: s_next.wc_ip = wd[BIT_WRITE_COMPLETE];
          SEL_NONE: s_next.unlock = UNL_IDLE;
        endcase
      end
    end

    // self-timed cycle: erase half then program half [RULE14] [RULE21]
    unique case (s_reg.phase)
      PH_IDLE: begin
      end
      PH_ERASE: begin
        s_next.cnt = s_reg.cnt + CNT_ONE;
        if (s_reg.cnt == ERASE_LAST) begin
          s_next.phase = PH_PROGRAM;
          s_next.cnt = '0;
        end
      end
      PH_PROGRAM: begin
        s_next.cnt = s_reg.cnt + CNT_ONE;
        if (s_reg.cnt == PROGRAM_LAST) begin
          s_next.phase = PH_IDLE;
          s_next.cnt = '0;
          s_next.write_start = 1'b0; // [RULE7]
          s_next.write_abort = 1'b0; // [RULE5]
          s_next.wc_flag = 1'b1; // completion wins over a same-cycle clear [RULE8]
          if (s_reg.target == TGT_FLASH) begin
            s_next.row_erase = 1'b0; // [RULE13]
          end
          mem_we = (s_reg.target == TGT_EEPROM);
          mem_wdata = s_reg.data;
        end
      end
      default: s_next.phase = PH_IDLE;
    endcase

    // axi read
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rval;
      s_next.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  // ----------------------------------------------------------------------
  // warm reset image: abort flag and space selects survive [RULE6] [RULE15]
  // ----------------------------------------------------------------------
  always_comb begin
    warm = STATE_POR;
    warm.program_space = s_reg.program_space;
    warm.config_space = s_reg.config_space;
    warm.write_abort = s_reg.write_abort; // a cut-short cycle leaves it at 1 [RULE6]
  end

  // power-on clears everything, enable and starts included [RULE4] [RULE16]
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      s_reg <= STATE_POR;
    end else if (!aresetn) begin
      s_reg <= warm;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // one transaction of each kind at a time keeps the slave simple
  assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  // flash side only sees starts for its own targets [RULE13]
  assign nvm_cmd.start = s_reg.cmd_start && (s_reg.target != TGT_EEPROM);
  assign nvm_cmd.row_erase = s_reg.row_erase;
  assign nvm_cmd.target = s_reg.target;
  assign nvm_cmd.busy = s_reg.write_start;

  assign irq_req = s_reg.wc_flag && s_reg.wc_ie; // [RULE22]
  assign irq_high_priority = s_reg.wc_flag && s_reg.wc_ie && s_reg.wc_ip; // [RULE22]

endmodule
`default_nettype wire

// ==== verif/nvm_access_ctrl_props.sv ====
// checker for the nvm access controller, watching its top-level ports only.
// assumes one aclk domain; both resets are active low and synchronous.
`default_nettype none
module nvm_access_ctrl_props
  import nvm_ctrl_pkg::*;
#(
  parameter int WRITE_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire nvm_cmd_s nvm_cmd,
  input wire logic irq_req,
  input wire logic irq_high_priority
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);

  // ----------------------------------------------------------------------
  // helper: length of the current self-timed cycle
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] busy_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !por_n || !nvm_cmd.busy) begin
      busy_cnt_reg <= '0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_prio_needs_req: assert property (irq_high_priority |-> irq_req)
    else $error("priority request without request");
  a_start_one_pulse: assert property (nvm_cmd.start |=> !nvm_cmd.start)
    else $error("start pulse longer than one cycle");
  a_start_with_busy: assert property (nvm_cmd.start |-> nvm_cmd.busy)
    else $error("start without write bit");
  a_start_not_eeprom: assert property (
    nvm_cmd.start |-> nvm_cmd.target != TGT_EEPROM)
    else $error("flash command aimed at eeprom");
  a_target_frozen: assert property (
    $past(nvm_cmd.busy, 2) && nvm_cmd.busy |-> $stable(nvm_cmd.target))
    else $error("target moved during a write");
  // a cycle cut short by a reset is short on purpose and is not measured
  a_busy_span_len: assert property (
    $fell(nvm_cmd.busy) && $past(aresetn) && $past(por_n)
    |-> busy_cnt_reg == CNT_W'(WRITE_CYCLES))
    else $error("self-timed cycle of wrong length");
  a_busy_on_resp: assert property ($rose(nvm_cmd.busy) |-> s_axi_bvalid)
    else $error("write started without a bus write");
  a_erase_bit_cleared: assert property (
    $fell(nvm_cmd.busy) && nvm_cmd.target == TGT_FLASH |-> ##[0:1] !nvm_cmd.row_erase)
    else $error("row erase bit kept after erase");
  a_upper_bytes_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bytes not zero");

  c_flash_start: cover property (nvm_cmd.start);
  c_write_done: cover property ($fell(nvm_cmd.busy));
  c_irq_high: cover property (irq_high_priority);
endmodule
`default_nettype wire

// ==== verif/flash_side_model.sv ====
// flash and configuration side: counts every start the controller sends and keeps the target and erase bit of the last.
// assumes nvm_cmd.start is a one-cycle pulse on aclk; timing is the controller's.
`default_nettype none
module flash_side_model
  import nvm_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire nvm_cmd_s nvm_cmd,
  output logic [7:0] start_cnt,
  output target_e last_target,
  output logic last_erase
);
  initial begin
    start_cnt = 8'h00;
    last_target = TGT_EEPROM;
    last_erase = 1'b0;
  end
  always @(posedge aclk) begin
    if (nvm_cmd.start) begin
      start_cnt <= start_cnt + 8'h01;
      last_target <= nvm_cmd.target;
      last_erase <= nvm_cmd.row_erase;
    end
  end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the nvm access controller over axi4-lite.
// assumes a short write timer (40 cycles) so self-timed cycles end quickly.
`default_nettype none
module testbench
  import nvm_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic por_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_req, irq_hi, last_erase;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] start_cnt;
  nvm_cmd_s nvm_cmd;
  target_e last_target;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] sel[3] = '{8'h80, 8'h40, 8'hC0};
  logic [7:0] cfg[2] = '{8'h94, 8'h44};
  target_e tgt[2] = '{TGT_FLASH, TGT_CONFIG};

  always #12.5 aclk = ~aclk;

  nvm_access_ctrl #(.WRITE_CYCLES(40), .ERASE_CYCLES(20)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nvm_cmd(nvm_cmd),
    .irq_req(irq_req), .irq_high_priority(irq_hi)
  );
  flash_side_model far_u (.aclk(aclk), .nvm_cmd(nvm_cmd), .start_cnt(start_cnt),
    .last_target(last_target), .last_erase(last_erase));

  // ----------------------------------------------------------------------
  // checks and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  // unlock keys go straight before the start write, nothing in between
  task automatic arm(input logic [7:0] c);
    wr(OFS_ACCESS_CONTROL, {24'h0, c});
    wr(OFS_UNLOCK_KEY, {24'h0, KEY_FIRST});
    wr(OFS_UNLOCK_KEY, {24'h0, KEY_SECOND});
    wr(OFS_ACCESS_CONTROL, {24'h0, c | 8'h02});
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(OFS_ACCESS_CONTROL);
      n++;
    end while (d[BIT_WRITE_START] !== 1'b0 && n < 40);
  endtask
  task automatic set_addr(input logic [9:0] a);
    wr(OFS_ADDRESS_LOW, {24'h0, a[7:0]});
    wr(OFS_ADDRESS_HIGH, {30'h0, a[9:8]});
  endtask
  task automatic ee_read(input logic [9:0] a);
    set_addr(a);
    wr(OFS_ACCESS_CONTROL, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    rd(OFS_DATA_PORT);
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    #(25 * 10000);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    rd(OFS_ACCESS_CONTROL);
    chk(d, 32'h0000_0000);
    rd(OFS_UNLOCK_KEY);
    chk(d, 32'h0000_0000);
    rd(8'h20);
    chk_resp(r, RESP_SLVERR);
    wr(8'h24, 32'h0000_00FF);
    chk_resp(r, RESP_SLVERR);
    set_addr(10'h3A5);
    wr(OFS_DATA_PORT, 32'h0000_005C);
    arm(8'h04);
    rd(OFS_ACCESS_CONTROL);
    chk(d, 32'h0000_000E);
    wr(OFS_ACCESS_CONTROL, 32'h0000_0004);
    wr(OFS_ADDRESS_HIGH, 32'h0000_0000);
    rd(OFS_ACCESS_CONTROL);
    chk(d, 32'h0000_000E);
    wait_done();
    chk(d, 32'h0000_0004);
    rd(OFS_FLAGS_2);
    chk(d, 32'h0000_0010);
    set_addr(10'h0A5);
    wr(OFS_DATA_PORT, 32'h0000_00C3);
    arm(8'h04);
    wait_done();
    ee_read(10'h3A5);
    chk(d, 32'h0000_005C);
    rd(OFS_ACCESS_CONTROL);
    chk(d, 32'h0000_0000);
    rd(OFS_DATA_PORT);
    chk(d, 32'h0000_005C);
    ee_read(10'h0A5);
    chk(d, 32'h0000_00C3);
    wr(OFS_ENABLES_2, 32'h0000_0010);
    wr(OFS_PRIORITY_2, 32'h0000_0010);
    repeat (2) @(posedge aclk);
    chk({30'h0, irq_req, irq_hi}, 32'h0000_0003);
    wr(OFS_FLAGS_2, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk({30'h0, irq_req, irq_hi}, 32'h0000_0000);
    wr(OFS_ACCESS_CONTROL, 32'h0000_0004);
    wr(OFS_UNLOCK_KEY, 32'h0000_0055);
    wr(OFS_ACCESS_CONTROL, 32'h0000_0006);
    rd(OFS_ACCESS_CONTROL);
    chk(d, 32'h0000_000C);
    wr(OFS_ACCESS_CONTROL, 32'h0000_0000);
    wr(OFS_UNLOCK_KEY, 32'h0000_0055);
    wr(OFS_UNLOCK_KEY, 32'h0000_00AA);
    wr(OFS_ACCESS_CONTROL, 32'h0000_0006);
    rd(OFS_ACCESS_CONTROL);
    chk(d, 32'h0000_000C);
    foreach (sel[i]) begin
      wr(OFS_ACCESS_CONTROL, {24'h0, sel[i] | 8'h01});
      rd(OFS_ACCESS_CONTROL);
      chk(d, {24'h0, sel[i]});
    end
    for (int i = 0; i < 2; i++) begin
      arm(cfg[i]);
      wait_done();
      chk(d, {24'h0, cfg[i] & 8'hEF});
      chk({21'h0, start_cnt, last_erase, last_target},
        {21'h0, 8'(i + 1), cfg[i][4], tgt[i]});
    end
    // warm reset in mid-cycle must leave the failed target visible
    arm(8'h84);
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_ACCESS_CONTROL);
    chk(d, 32'h0000_0088);
    close_out();
  end
endmodule

bind nvm_access_ctrl nvm_access_ctrl_props #(.WRITE_CYCLES(WRITE_CYCLES)) props_u (
  .aclk, .aresetn, .por_n, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .nvm_cmd,
  .irq_req, .irq_high_priority
);
`default_nettype wire
